// [verilog/port_alt_function_control.sv]
`timescale 1ns/10ps
module port_alt_function_control
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [7:0]  i_p4_alt,
  input  wire logic [7:0]  i_p5_alt1,
  input  wire logic [7:0]  i_p5_alt2,
  input  wire logic [15:0] i_p9_alt1,
  input  wire logic [15:0] i_p9_alt2,
  input  wire logic [7:0]  i_p4_pin,
  input  wire logic [7:0]  i_p5_pin,
  input  wire logic [15:0] i_p9_pin,
  output logic      [7:0]  o_p4_out,
  output logic      [7:0]  o_p4_oe,
  output logic      [7:0]  o_p5_out,
  output logic      [7:0]  o_p5_oe,
  output logic      [15:0] o_p9_out,
  output logic      [15:0] o_p9_oe
);

  typedef struct packed {
    logic [7:0]  port4_latch_bit;
    logic [7:0]  p4_dir;
    logic [7:0]  port4_mode_control;
    logic [7:0]  port4_open_drain_select;
    logic [7:0]  p5_latch;
    logic [7:0]  p5_dir;
    logic [7:0]  port5_mode_control;
    logic [7:0]  port5_function_select;
    logic [15:0] port9_data_reg;
    logic [15:0] port9_direction_reg;
    logic [15:0] port9_mode_control_reg;
    logic [15:0] port9_function_select_reg;
    logic [15:0] port9_open_drain_select;
    logic [15:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   [7:0]  p4_val;
  logic   [7:0]  p5_val;
  logic   [15:0] p9_val;
  logic   [7:0]  p5_drv;
  logic   [15:0] p9_drv;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    if (i_wr)
    begin
      case (i_addr)
        port_alt_pkg::A_P4_LATCH: s_d.port4_latch_bit = i_wdata[7:0];
        port_alt_pkg::A_P4_DIR:   s_d.p4_dir = i_wdata[7:0];
        port_alt_pkg::A_P4_MODE:  s_d.port4_mode_control = i_wdata[7:0];
        port_alt_pkg::A_P4_OD:    s_d.port4_open_drain_select = i_wdata[7:0];
        port_alt_pkg::A_P5_LATCH: s_d.p5_latch = i_wdata[7:0];
        port_alt_pkg::A_P5_DIR:   s_d.p5_dir = i_wdata[7:0];
        port_alt_pkg::A_P5_MODE:  s_d.port5_mode_control = i_wdata[7:0];
        port_alt_pkg::A_P5_FSEL:  s_d.port5_function_select = i_wdata[7:0];
        port_alt_pkg::A_P9_DATA:  s_d.port9_data_reg = i_wdata;
        // high alias writes
        // data high alias
        port_alt_pkg::A_P9_DATAH: s_d.port9_data_reg[15:8] = i_wdata[7:0];
        port_alt_pkg::A_P9_DIR:   s_d.port9_direction_reg = i_wdata;
        port_alt_pkg::A_P9_DIRH:
          s_d.port9_direction_reg[15:8] = i_wdata[7:0];
        port_alt_pkg::A_P9_MODE:  s_d.port9_mode_control_reg = i_wdata;
        port_alt_pkg::A_P9_MODEH:
          s_d.port9_mode_control_reg[15:8] = i_wdata[7:0];
        port_alt_pkg::A_P9_FSEL:  s_d.port9_function_select_reg = i_wdata;
        port_alt_pkg::A_P9_FSELH:
          s_d.port9_function_select_reg[15:8] = i_wdata[7:0];
        port_alt_pkg::A_P9_OD:    s_d.port9_open_drain_select = i_wdata;
        default: ;
      endcase
    end
    s_d.rdata = 16'h0000;
    if (i_rd)
    begin
      case (i_addr)
        port_alt_pkg::A_P4_LATCH: s_d.rdata = {8'h00, s_q.port4_latch_bit};
        port_alt_pkg::A_P4_DIR:   s_d.rdata = {8'h00, s_q.p4_dir};
        port_alt_pkg::A_P4_MODE:
          s_d.rdata = {8'h00, s_q.port4_mode_control};
        port_alt_pkg::A_P4_OD:
          s_d.rdata = {8'h00, s_q.port4_open_drain_select};
        port_alt_pkg::A_P5_LATCH: s_d.rdata = {8'h00, s_q.p5_latch};
        port_alt_pkg::A_P5_DIR:   s_d.rdata = {8'h00, s_q.p5_dir};
        port_alt_pkg::A_P5_MODE:
          s_d.rdata = {8'h00, s_q.port5_mode_control};
        port_alt_pkg::A_P5_FSEL:
          s_d.rdata = {8'h00, s_q.port5_function_select};
        port_alt_pkg::A_P9_DATA:  s_d.rdata = s_q.port9_data_reg;
        port_alt_pkg::A_P9_DATAH:
          s_d.rdata = {8'h00, s_q.port9_data_reg[15:8]};
        port_alt_pkg::A_P9_DIR:   s_d.rdata = s_q.port9_direction_reg;
        port_alt_pkg::A_P9_DIRH:
          s_d.rdata = {8'h00, s_q.port9_direction_reg[15:8]};
        port_alt_pkg::A_P9_MODE:  s_d.rdata = s_q.port9_mode_control_reg;
        port_alt_pkg::A_P9_MODEH:
          s_d.rdata = {8'h00, s_q.port9_mode_control_reg[15:8]};
        port_alt_pkg::A_P9_FSEL:
          s_d.rdata = s_q.port9_function_select_reg;
        port_alt_pkg::A_P9_FSELH:
          s_d.rdata = {8'h00, s_q.port9_function_select_reg[15:8]};
        port_alt_pkg::A_P9_OD:    s_d.rdata = s_q.port9_open_drain_select;
        port_alt_pkg::A_P4_PIN:   s_d.rdata = {8'h00, i_p4_pin};
        port_alt_pkg::A_P5_PIN:   s_d.rdata = {8'h00, i_p5_pin};
        port_alt_pkg::A_P9_PIN:   s_d.rdata = i_p9_pin;
        default:                  s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q.port4_latch_bit           <= port_alt_pkg::RST_BYTE;
      s_q.p4_dir                    <= port_alt_pkg::RST_DIR8;
      s_q.port4_mode_control        <= port_alt_pkg::RST_BYTE;
      s_q.port4_open_drain_select   <= port_alt_pkg::RST_BYTE;
      s_q.p5_latch                  <= port_alt_pkg::RST_BYTE;
      s_q.p5_dir                    <= port_alt_pkg::RST_DIR8;
      s_q.port5_mode_control        <= port_alt_pkg::RST_BYTE;
      s_q.port5_function_select     <= port_alt_pkg::RST_BYTE;
      s_q.port9_data_reg            <= port_alt_pkg::RST_WORD;
      s_q.port9_direction_reg       <= port_alt_pkg::RST_DIR16;
      s_q.port9_mode_control_reg    <= port_alt_pkg::RST_WORD;
      s_q.port9_function_select_reg <= port_alt_pkg::RST_WORD;
      s_q.port9_open_drain_select   <= port_alt_pkg::RST_WORD;
      s_q.rdata                     <= port_alt_pkg::RST_WORD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive; direction 1 means input
  always_comb
  begin
    p5_drv = s_q.port5_mode_control & port_alt_pkg::P5_FSEL_MASK
             & ~s_q.port5_function_select;
    p9_drv = s_q.port9_mode_control_reg & port_alt_pkg::P9_FSEL_MASK
             & ~s_q.port9_function_select_reg;
    p4_val = (s_q.port4_mode_control & i_p4_alt)
           | (~s_q.port4_mode_control & s_q.port4_latch_bit);
    p5_val = ((s_q.port5_mode_control
               & ((s_q.port5_function_select & i_p5_alt2)
                | (~s_q.port5_function_select & i_p5_alt1)))
           | (~s_q.port5_mode_control & s_q.p5_latch)) & ~p5_drv;
    p9_val = ((s_q.port9_mode_control_reg
               & ((s_q.port9_function_select_reg & i_p9_alt2)
                | (~s_q.port9_function_select_reg & i_p9_alt1)))
           | (~s_q.port9_mode_control_reg & s_q.port9_data_reg)) & ~p9_drv;
  end

  assign o_p4_out = p4_val;
  assign o_p5_out = p5_val;
  assign o_p9_out = p9_val;
  assign o_p4_oe = (s_q.port4_mode_control | ~s_q.p4_dir)
                   & ~(s_q.port4_open_drain_select & p4_val);
  assign o_p5_oe = s_q.port5_mode_control | ~s_q.p5_dir;
  assign o_p9_oe = (s_q.port9_mode_control_reg | ~s_q.port9_direction_reg)
                   & ~(s_q.port9_open_drain_select & p9_val);

  ////////////////////////////////////////////////////////////////////////////
  property p_data_alias;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_wr && i_addr == port_alt_pkg::A_P9_DATAH |=>
      s_q.port9_data_reg[15:8] == $past(i_wdata[7:0])
      && s_q.port9_data_reg[7:0] == $past(s_q.port9_data_reg[7:0]);
  endproperty
  a_data_alias: assert property (p_data_alias)
    else $error("data high alias write wrong");

  property p_dir_alias;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_rd && i_addr == port_alt_pkg::A_P9_DIRH |=>
      o_rdata == {8'h00, $past(s_q.port9_direction_reg[15:8])};
  endproperty
  a_dir_alias: assert property (p_dir_alias)
    else $error("direction alias read wrong");

  property p_mode_alias;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_wr && i_addr == port_alt_pkg::A_P9_MODEH |=>
      s_q.port9_mode_control_reg[15:8] == $past(i_wdata[7:0]);
  endproperty
  a_mode_alias: assert property (p_mode_alias)
    else $error("mode alias write wrong");

  property p_fsel_alias;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_rd && i_addr == port_alt_pkg::A_P9_FSELH |=>
      o_rdata[7:0] == $past(s_q.port9_function_select_reg[15:8])
      && o_rdata[15:8] == 8'h00;
  endproperty
  a_fsel_alias: assert property (p_fsel_alias)
    else $error("fsel alias read wrong");

  property p_port_mode;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    !s_q.port9_mode_control_reg[0] |->
      o_p9_out[0] == s_q.port9_data_reg[0]
      && o_p9_oe[0] == (!s_q.port9_direction_reg[0]
                        && !(s_q.port9_open_drain_select[0]
                             && s_q.port9_data_reg[0]));
  endproperty
  a_port_mode: assert property (p_port_mode)
    else $error("port mode drive wrong");

  property p_alt_mode;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.port4_mode_control[1] |-> o_p4_out[1] == i_p4_alt[1];
  endproperty
  a_alt_mode: assert property (p_alt_mode)
    else $error("alt mode drive wrong");

  property p_open_drain;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.port9_open_drain_select[8] && o_p9_out[8] |-> !o_p9_oe[8];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drove a one");

  property p_undef5;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.port5_mode_control[4] && !s_q.port5_function_select[4]
      |-> !o_p5_out[4];
  endproperty
  a_undef5: assert property (p_undef5)
    else $error("port5 undefined alt not low");

  property p_undef9;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.port9_mode_control_reg[13] && !s_q.port9_function_select_reg[13]
      |-> !o_p9_out[13];
  endproperty
  a_undef9: assert property (p_undef9)
    else $error("port9 undefined alt not low");

  c_od_seq: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.port9_open_drain_select[9] && s_q.port9_mode_control_reg[9]);
  c_alias_wr: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    i_wr && i_addr == port_alt_pkg::A_P9_DATAH);
  c_alt2: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    s_q.port5_mode_control[3] && s_q.port5_function_select[3]);

endmodule

// [verilog/port_alt_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Function
// - Port 5 pins 3 to 5 in alternate mode with function select 0 give an undefined output, shown here as driven low.
// - Bits 8 to 15 of the port 9 data register also read and write as bits 0 to 7 of a high alias.
// - Bits 8 to 15 of the port 9 direction register also read and write as bits 0 to 7 of a high alias.
// - Bits 8 to 15 of the port 9 mode control register also read and write as bits 0 to 7 of a high alias.
// - Bits 8 to 15 of the port 9 function select register also read and write as bits 0 to 7 of a high alias.
// - Port 9 pins 0, 1, 6 to 9 and 13 to 15 in alternate mode with function select 0 give an undefined output, shown here as driven low.
//////////////////////////////////////////////////////////////////////////////
package port_alt_pkg;
  localparam int          ADDR_W = 5;
  localparam logic [4:0]  A_P4_LATCH = 5'h00;
  localparam logic [4:0]  A_P4_DIR   = 5'h01;
  localparam logic [4:0]  A_P4_MODE  = 5'h02;
  localparam logic [4:0]  A_P4_OD    = 5'h03;
  localparam logic [4:0]  A_P5_LATCH = 5'h04;
  localparam logic [4:0]  A_P5_DIR   = 5'h05;
  localparam logic [4:0]  A_P5_MODE  = 5'h06;
  localparam logic [4:0]  A_P5_FSEL  = 5'h07;
  localparam logic [4:0]  A_P9_DATA  = 5'h08;
  localparam logic [4:0]  A_P9_DATAH = 5'h09;
  localparam logic [4:0]  A_P9_DIR   = 5'h0a;
  localparam logic [4:0]  A_P9_DIRH  = 5'h0b;
  localparam logic [4:0]  A_P9_MODE  = 5'h0c;
  localparam logic [4:0]  A_P9_MODEH = 5'h0d;
  localparam logic [4:0]  A_P9_FSEL  = 5'h0e;
  localparam logic [4:0]  A_P9_FSELH = 5'h0f;
  localparam logic [4:0]  A_P9_OD    = 5'h10;
  localparam logic [4:0]  A_P4_PIN   = 5'h11;
  localparam logic [4:0]  A_P5_PIN   = 5'h12;
  localparam logic [4:0]  A_P9_PIN   = 5'h13;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_DIR8   = 8'hff;
  localparam logic [15:0] RST_DIR16  = 16'hffff;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  // pins whose alternate output needs function select 1
  localparam logic [7:0]  P5_FSEL_MASK = 8'h38;
  localparam logic [15:0] P9_FSEL_MASK = 16'he3c3;
endpackage

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
  logic        i_sys_clk;
  logic        i_arst_n;
  logic [4:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic [7:0]  i_p4_alt, i_p5_alt1, i_p5_alt2, i_p4_pin, i_p5_pin;
  logic [7:0]  o_p4_out, o_p4_oe, o_p5_out, o_p5_oe;
  logic [15:0] i_p9_alt1, i_p9_alt2, i_p9_pin, o_p9_out, o_p9_oe;
  logic [15:0] m [0:31];
  logic [31:0] seed;
  logic [31:0] r;
  logic [4:0]  ab;
  int          err_total;
  int          cmp_count;

  port_alt_function_control u_port_alt_function_control
  (
    .i_sys_clk (i_sys_clk), .i_arst_n (i_arst_n), .i_addr (i_addr),
    .i_wdata (i_wdata), .i_wr (i_wr), .i_rd (i_rd), .o_rdata (o_rdata),
    .i_p4_alt (i_p4_alt), .i_p5_alt1 (i_p5_alt1), .i_p5_alt2 (i_p5_alt2),
    .i_p9_alt1 (i_p9_alt1), .i_p9_alt2 (i_p9_alt2), .i_p4_pin (i_p4_pin),
    .i_p5_pin (i_p5_pin), .i_p9_pin (i_p9_pin), .o_p4_out (o_p4_out),
    .o_p4_oe (o_p4_oe), .o_p5_out (o_p5_out), .o_p5_oe (o_p5_oe),
    .o_p9_out (o_p9_out), .o_p9_oe (o_p9_oe)
  );

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {oe, out masked by oe} of one port
  function automatic logic [31:0] pin_exp(input logic [15:0] lat, dir, mode,
    fsel, od, a1, a2, mask);
    logic [15:0] v;
    logic [15:0] oe;
    for (int b = 0; b < 16; b++)
    begin
      if (mode[b])
      begin
        v[b] = fsel[b] ? a2[b] : (mask[b] ? 1'b0 : a1[b]);
        oe[b] = 1'b1;
      end
      else
      begin
        v[b] = lat[b];
        oe[b] = ~dir[b];
      end
      if (od[b] && v[b])
        oe[b] = 1'b0;
    end
    return {oe, v & oe};
  endfunction

  function automatic logic [15:0] rd_exp(input logic [4:0] a);
    if (a <= 5'h07 || a == 5'h10 || (a <= 5'h0f && !a[0]))
      return m[a];
    else if (a <= 5'h0f)
      return {8'h00, m[a - 5'h01][15:8]};
    else if (a == 5'h11)
      return {8'h00, i_p4_pin};
    else if (a == 5'h12)
      return {8'h00, i_p5_pin};
    else if (a == 5'h13)
      return i_p9_pin;
    return 16'h0000;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  task automatic cmp_rd(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD o_rdata addr %h exp %h got %h", i_addr, exp, got);
    end
  endtask

  task automatic cmp_pin(input string nm, input logic [15:0] exp,
    input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic check_pins();
    logic [31:0] e;
    e = pin_exp(m[0], m[1], m[2], 16'h0000, m[3], {8'h00, i_p4_alt},
      16'h0000, 16'h0000);
    cmp_pin("p4_oe", {8'h00, e[23:16]}, {8'h00, o_p4_oe});
    cmp_pin("p4_out", {8'h00, e[7:0]}, {8'h00, o_p4_out & o_p4_oe});
    e = pin_exp(m[4], m[5], m[6], m[7], 16'h0000, {8'h00, i_p5_alt1},
      {8'h00, i_p5_alt2}, {8'h00, port_alt_pkg::P5_FSEL_MASK});
    cmp_pin("p5_oe", {8'h00, e[23:16]}, {8'h00, o_p5_oe});
    cmp_pin("p5_out", {8'h00, e[7:0]}, {8'h00, o_p5_out & o_p5_oe});
    e = pin_exp(m[8], m[10], m[12], m[14], m[16], i_p9_alt1, i_p9_alt2,
      port_alt_pkg::P9_FSEL_MASK);
    cmp_pin("p9_oe", e[31:16], o_p9_oe);
    cmp_pin("p9_out", e[15:0], o_p9_out & o_p9_oe);
  endtask

  // one bus access with fresh random pin-side inputs, then all checks
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr <= w;
    i_rd <= ~w;
    i_addr <= a;
    i_wdata <= d;
    i_p4_alt <= 8'(next_rand());
    {i_p5_alt1, i_p5_alt2, i_p4_pin, i_p5_pin} <= next_rand();
    {i_p9_alt1, i_p9_alt2} <= next_rand();
    i_p9_pin <= 16'(next_rand());
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    if (w && a <= 5'h07)
      m[a] = {8'h00, d[7:0]};
    else if (w && a <= 5'h0f && a[0])
      m[a - 5'h01][15:8] = d[7:0];
    else if (w && a <= 5'h10)
      m[a] = d;
    #1;
    cmp_rd(w ? 16'h0 : rd_exp(a), o_rdata);
    check_pins();
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  initial
  begin
    #25000;
    err_total++;
    conclude();
  end

  initial
  begin
    seed = 32'h49e4;
    err_total = 0;
    cmp_count = 0;
    {i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_p4_alt, i_p5_alt1, i_p5_alt2, i_p4_pin, i_p5_pin} = '0;
    {i_p9_alt1, i_p9_alt2, i_p9_pin} = '0;
    foreach (m[k])
      m[k] = 16'h0000;
    m[1] = {8'h00, port_alt_pkg::RST_DIR8};
    m[5] = {8'h00, port_alt_pkg::RST_DIR8};
    m[10] = port_alt_pkg::RST_DIR16;
    repeat (12) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    for (int a = 0; a < 32; a++)
      acc(1'b0, a[4:0], 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      r = next_rand();
      ab = 5'h08 + 5'(2 * k);
      acc(1'b1, ab, r[15:0]);
      acc(1'b0, ab + 5'h01, 16'h0000);
      acc(1'b1, ab + 5'h01, r[31:16]);
      acc(1'b0, ab, 16'h0000);
    end
    // open-drain alternate output on port 4 pins 1 and 2
    acc(1'b1, port_alt_pkg::A_P4_LATCH, 16'h0006);
    acc(1'b1, port_alt_pkg::A_P4_OD, 16'h0006);
    acc(1'b1, port_alt_pkg::A_P4_MODE, 16'h0006);
    // open-drain alternate output on port 9 pins 8 and 9
    acc(1'b1, port_alt_pkg::A_P9_DATAH, 16'h0003);
    acc(1'b1, port_alt_pkg::A_P9_FSELH, 16'h0002);
    acc(1'b1, port_alt_pkg::A_P9_OD, 16'h0300);
    acc(1'b1, port_alt_pkg::A_P9_MODEH, 16'h0003);
    // alternate mode before function select on port 5
    acc(1'b1, port_alt_pkg::A_P5_MODE, 16'h003f);
    acc(1'b1, port_alt_pkg::A_P5_FSEL, 16'h0038);
    repeat (400)
    begin
      r = next_rand();
      acc(r[5], r[4:0], r[31:16]);
    end
    conclude();
  end
endmodule
